// ---- shared/slpr_pkg.sv ----
// slpr_pkg: constants and types of the serial load port and phase resync timer
// assumes a 100 MHz system clock and AXI4-Lite with 32-bit data
package slpr_pkg;
  localparam int WORD_W        = 29;
  localparam int SEL_W         = 3;
  localparam int FIELD_W       = 12;
  localparam int NUM_LATCH     = 8;
  // latch selector bits of the shifted word
  localparam int SEL_LSB       = 0;
  // word indices
  localparam logic [2:0] IDX_FREQ  = 3'h0;
  localparam logic [2:0] IDX_MOD   = 3'h1;
  localparam logic [2:0] IDX_FUNC  = 3'h3;
  localparam logic [2:0] IDX_SYNC  = 3'h4;
  // field positions
  localparam int MODE_LSB      = 19;
  localparam int DIV_LSB       = 7;
  localparam int MODULUS_LSB   = 3;
  localparam int PHASE_LSB     = 15;
  localparam int RESEED_BIT    = 14;
  localparam logic [1:0] MODE_RESYNC = 2'h2;
  // resync counts the second pulse after a frequency load
  localparam logic [1:0] ALIGN_PULSE = 2'h2;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PULSES = 8'h08;
  localparam logic [7:0] OFS_PHASE  = 8'h0c;
  localparam logic [7:0] OFS_LATCH0 = 8'h20;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [WORD_W-1:0] LATCH_RST = 29'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [1:0]         mode;
    logic [FIELD_W-1:0] div;
    logic [FIELD_W-1:0] modulus;
    logic [FIELD_W-1:0] phase;
    logic               reseed_n;
  } slpr_fields_t;

  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic latch_strobe;
    logic ref_clk;
  } slpr_pins_t;
endpackage

// ---- hdl/slpr_top.sv ----
// slpr_top: serial load port, control latches, phase resync timer, AXI4-Lite slave
// assumes serial pins and the reference clock are asynchronous to clk
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps

// Summary of operation
// - resync runs only when mode bits 20:19 of control word four read 1,0.
// - while enabled and CTRL bit 0 is set, a sync pulse fires every divider times modulus reference periods.
// - the divider is the 12-bit field at bits 18:7 of control word four, 1 to 4095.
// - the modulus is the 12-bit field at bits 14:3 of the modulus control word.
// - the second sync pulse after a frequency-load strobe realigns the output phase.
// - the phase word sets the output offset in steps of 360 degrees over the modulus.
// - one data bit shifts into the 29-bit input register per serial clock rising edge.
// - a latch strobe rising edge moves the input register into the latch it selects.
// - with the reseed bit 14 of word three at zero, each word zero write reseeds the modulator.
module slpr_top
  import slpr_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire slpr_pkg::slpr_pins_t        pins,
  output logic                             sync_pulse,
  output logic                             realign_pulse,
  output logic                             reseed_pulse,
  output logic [slpr_pkg::FIELD_W-1:0]     phase_offset,
  output logic [slpr_pkg::FIELD_W-1:0]     modulus_out,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import slpr_pkg::*;

  function automatic logic [FIELD_W-1:0] fld(input logic [WORD_W-1:0] w, input int lsb);
    fld = FIELD_W'(w >> lsb);
  endfunction

  // two-flop synchronisers
  slpr_pins_t          pin_s1_r;
  slpr_pins_t          pin_s2_r;
  slpr_pins_t          pin_d_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r  <= '0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  logic                sclk_rise;
  logic                strobe_rise;
  logic                ref_rise;
  assign sclk_rise   = pin_s2_r.ser_clk & ~pin_d_r.ser_clk;
  assign strobe_rise = pin_s2_r.latch_strobe & ~pin_d_r.latch_strobe;
  assign ref_rise    = pin_s2_r.ref_clk & ~pin_d_r.ref_clk;

  // input shift register
  logic [WORD_W-1:0]   shift_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      shift_r <= LATCH_RST;
    else if (sclk_rise)
      shift_r <= {shift_r[WORD_W-2:0], pin_s2_r.ser_data};
  end

  // control latches
  logic [WORD_W-1:0]   latch_r [NUM_LATCH];
  logic [SEL_W-1:0]    sel;
  logic                freq_load;
  assign sel       = shift_r[SEL_LSB +: SEL_W];
  assign freq_load = strobe_rise && sel == IDX_FREQ;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_LATCH; i++)
        latch_r[i] <= LATCH_RST;
    end else if (strobe_rise) begin
      latch_r[sel] <= shift_r;
    end
  end

  slpr_fields_t        f;
  always_comb begin
    f.mode     = latch_r[IDX_SYNC][MODE_LSB +: 2];
    f.div      = fld(latch_r[IDX_SYNC], DIV_LSB);
    f.modulus  = fld(latch_r[IDX_MOD], MODULUS_LSB);
    f.phase    = fld(latch_r[IDX_MOD], PHASE_LSB);
    f.reseed_n = latch_r[IDX_FUNC][RESEED_BIT];
  end

  logic                resync_en;
  assign resync_en = f.mode == MODE_RESYNC;

  // resync timer
  logic [2*FIELD_W-1:0] period_r;
  logic [2*FIELD_W-1:0] tcnt_r;
  logic [1:0]           seen_r;
  logic [31:0]          ctrl_r;
  logic [31:0]          pulses_r;
  logic                 tick;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      period_r <= '0;
    else
      period_r <= f.div * f.modulus;
  end

  assign tick = resync_en && ref_rise && period_r != '0 && tcnt_r >= period_r - 1'b1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      tcnt_r <= '0;
    else if (freq_load || !resync_en || tick)
      tcnt_r <= '0;
    else if (ref_rise)
      tcnt_r <= tcnt_r + 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      seen_r <= ALIGN_PULSE;
    else if (freq_load)
      seen_r <= '0;
    else if (tick && seen_r != ALIGN_PULSE)
      seen_r <= seen_r + 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_pulse    <= 1'b0;
      realign_pulse <= 1'b0;
      phase_offset  <= '0;
    end else begin
      sync_pulse    <= tick & ctrl_r[0];
      realign_pulse <= tick && seen_r == ALIGN_PULSE - 1'b1;
      if (tick && seen_r == ALIGN_PULSE - 1'b1)
        phase_offset <= f.phase;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      pulses_r <= '0;
    else if (tick)
      pulses_r <= pulses_r + 1'b1;
  end

  // reseed and modulus outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reseed_pulse <= 1'b0;
      modulus_out  <= '0;
    end else begin
      reseed_pulse <= freq_load & ~f.reseed_n;
      modulus_out  <= f.modulus;
    end
  end

  // axi4-lite write channel
  logic                aw_held_r;
  logic                w_held_r;
  logic [7:0]          awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                do_write;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == OFS_CTRL) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      ctrl_r <= CTRL_RST;
    else if (do_write && awaddr_r == OFS_CTRL) begin
      for (int b = 0; b < 4; b++)
        if (wstrb_r[b])
          ctrl_r[8*b +: 8] <= wdata_r[8*b +: 8];
    end
  end

  // axi4-lite read channel
  logic [31:0]         rd_data;
  logic                rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    case (s_axi_araddr)
      OFS_CTRL:   rd_data = ctrl_r;
      OFS_STATUS: rd_data = {29'h0, seen_r, resync_en};
      OFS_PULSES: rd_data = pulses_r;
      OFS_PHASE:  rd_data = {20'h0, phase_offset};
      default: begin
        if (s_axi_araddr >= OFS_LATCH0 && s_axi_araddr < OFS_LATCH0 + 8'(4 * NUM_LATCH)
            && s_axi_araddr[1:0] == 2'h0)
          rd_data = {3'h0, latch_r[SEL_W'((s_axi_araddr - OFS_LATCH0) >> 2)]};
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- dv/slpr_props.sv ----
// slpr_props: port checks of slpr_top
// assumes the bench reset and the bind below
`timescale 1ns/10ps
module slpr_props
  import slpr_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        reset,
  input wire slpr_pkg::slpr_pins_t        pins,
  input wire logic                        sync_pulse,
  input wire logic                        realign_pulse,
  input wire logic                        reseed_pulse,
  input wire logic [slpr_pkg::FIELD_W-1:0] phase_offset,
  input wire logic [slpr_pkg::FIELD_W-1:0] modulus_out,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready
);
  // cycles since the strobe pin rose
  logic [7:0] age_r;
  logic       stb_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      age_r <= 8'hff;
      stb_r <= 1'b0;
    end else begin
      stb_r <= pins.latch_strobe;
      age_r <= (pins.latch_strobe && !stb_r) ? 8'h00 : age_r + {7'h0, age_r != 8'hff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_sync_spacing: assert property (sync_pulse |=> !sync_pulse [*8]) else $error("sync too close");
  a_realign_once: assert property (realign_pulse |=> !realign_pulse [*8]) else $error("realign twice");
  a_realign_late: assert property (realign_pulse |-> age_r > 8'h1e) else $error("realign early");
  a_phase_at_realign: assert property ($changed(phase_offset) |-> realign_pulse) else $error("phase moved");
  a_modulus_after_load: assert property ($changed(modulus_out) |-> age_r < 8'h0c) else $error("modulus moved");
  a_reseed_at_load: assert property (reseed_pulse |-> age_r < 8'h0c) else $error("stray reseed");
  a_reseed_quiet: assert property (reseed_pulse |=> !reseed_pulse [*8]) else $error("reseed repeats");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_launch: assert property ($changed(s_axi_rdata) |-> $rose(s_axi_rvalid))
    else $error("read data moved outside a read");
  c_sync: cover property (sync_pulse);
  c_realign: cover property (realign_pulse);
  c_reseed: cover property (reseed_pulse);
endmodule
bind slpr_top slpr_props slpr_props_inst (.clk, .reset, .pins, .sync_pulse, .realign_pulse, .reseed_pulse,
  .phase_offset, .modulus_out, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ---- dv/slpr_host.sv ----
// slpr_host: host side of the three-wire load port
// assumes clk is the bench clock; one word at a time
`timescale 1ns/10ps
module slpr_host
  import slpr_pkg::*;
(
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      latch_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // msb first, 160 ns serial clock, idle low
  task automatic send(input logic [WORD_W-1:0] w);
    @(posedge clk);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (8) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (8) @(posedge clk);
      ser_clk <= 1'b0;
    end
    ser_data <= ~w[0];
    repeat (8) @(posedge clk);
    latch_strobe <= 1'b1;
    repeat (8) @(posedge clk);
    latch_strobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- dv/tb_slpr_top.sv ----
// tb_slpr_top: self-checking bench of slpr_top
// assumes slpr_host drives the serial pins
`timescale 1ns/10ps
module tb_slpr_top;
  import slpr_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        rc = 1'b0;
  logic        sc, sd, ls, sync_pulse, realign_pulse, reseed_pulse;
  slpr_pins_t  pins;
  logic [11:0] phase_offset, modulus_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb = 4'hf;
  int          failures, samples_checked, ns, nr, nq, at, t1, t2;
  always #5 clk = ~clk;
  always #80 rc = ~rc;
  // reseed pulses can fire before a watch window opens
  always @(negedge clk)
    if (reseed_pulse === 1'b1) nq++;
  assign pins = {sc, sd, ls, rc};
  slpr_host slpr_host_inst (.clk(clk), .ser_clk(sc), .ser_data(sd), .latch_strobe(ls));
  slpr_top slpr_top_inst (.clk, .reset, .pins, .sync_pulse, .realign_pulse, .reseed_pulse, .phase_offset,
    .modulus_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // count pulses over n cycles
  task automatic watch(input int n);
    {ns, nr, at, t1, t2} = '0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (sync_pulse === 1'b1) begin
        ns++;
        if (ns == 1) t1 = i;
        if (ns == 2) t2 = i;
      end
      if (realign_pulse === 1'b1) begin
        nr++;
        at = i;
      end
    end
  endtask
  task automatic load(input logic rs_n, input logic [11:0] ph, input logic [11:0] dv, input int n);
    int q;
    slpr_host_inst.send({14'h0, rs_n, 11'h0, IDX_FUNC});
    slpr_host_inst.send({2'h0, ph, 12'h002, IDX_MOD});
    slpr_host_inst.send({8'h00, MODE_RESYNC, dv, 4'h0, IDX_SYNC});
    check({20'h0, modulus_out}, 32'h2);
    q = nq;
    slpr_host_inst.send({26'h0abcdef, IDX_FREQ});
    watch(n);
    check(nq - q, {31'h0, !rs_n});
    check(nr, 1);
    check({31'h0, at >= t2 - 1 && at <= t2 + 1}, 32'h1);
    check({31'h0, t1 inside {[32 * dv - 30 : 32 * dv - 10]}}, 32'h1);
    check({31'h0, t2 - t1 inside {[32 * dv - 1 : 32 * dv + 1]}}, 32'h1);
    check({20'h0, phase_offset}, {20'h0, ph});
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(OFS_CTRL, d, r);
    check(d, CTRL_RST);
    axi_rd(8'h40, d, r);
    check({30'h0, r}, {30'h0, RESP_DECERR});
    axi_wr(OFS_STATUS, 32'h3, r);
    check({30'h0, r}, {30'h0, RESP_DECERR});
    load(1'b0, 12'h005, 12'h001, 200);
    axi_rd(OFS_LATCH0 + 8'h10, d, r);
    check(d, {11'h0, MODE_RESYNC, 12'h001, 4'h0, IDX_SYNC});
    load(1'b1, 12'h009, 12'h003, 400);
    axi_wr(OFS_CTRL, 32'h0, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axi_rd(OFS_CTRL, d, r);
    check(d, 32'h0);
    slpr_host_inst.send({26'h0abcdef, IDX_FREQ});
    watch(200);
    check(ns, 0);
    axi_wr(OFS_CTRL, CTRL_RST, r);
  endtask
  task automatic t_off();
    logic [1:0] m [3] = '{2'h0, 2'h1, 2'h3};
    foreach (m[i]) begin
      slpr_host_inst.send({8'h00, m[i], 12'h001, 4'h0, IDX_SYNC});
      slpr_host_inst.send({26'h0abcdef, IDX_FREQ});
      watch(150);
      check(ns + nr, 0);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {failures, samples_checked} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_off();
    give_verdict();
  end
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule
